/* File: design/reader_mode_command_handler.sv */
// What this block does
// - after reset the block starts in data mode, forwarding tags unasked
// - data mode acts only on 01, 05 and 8110; others ignored
// - command 01 enters command mode; tags are stored, not forwarded
// - command 00 returns to data mode and answers done
// - every command in command mode gets exactly one answer
// - new baud rate takes effect right after its done is sent
// - command mode reports error 04 when buffer reaches three quarters
// - full buffer drops further tags; reports error 02 only in command mode
// - unasked tag sending resumes only in data mode, draining buffer
// - while draining, error 03 once buffer is no longer full
// - while draining, error 05 once buffer falls to one half
// - download mode carries out only 90, 91, 96, 97, 99, others answered error; tags held
// - download forces 9600 baud, one stop bit, no echo
// - exit download restarts: settings back to defaults, data mode
// - switch to download is refused with error in data mode
// - poll sends oldest buffered tag when protocol and buffering enabled
// - poll answers done when empty, error when not enabled
// - baud command last digit picks rate index 0 to 6
// - baud request below the timeout-allowed rate is refused
// - stop bit command digit 0 gives one, 1 gives two
`timescale 1ns/1ns
module reader_mode_command_handler (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    cmdValid,
  input  wire logic                    cmdLong,
  input  wire logic [15:0]             cmdCode,
  output      logic                    cmdBusy,
  input  wire logic                    tagValid,
  input  wire logic [reader_pkg::TAG_W-1:0] tagId,
  output      logic                    tagReady,
  input  wire logic                    ecpEnable,
  input  wire logic                    bufCtrlEnable,
  input  wire logic [2:0]              ecpMinBaud,
  input  wire logic                    outReady,
  output      logic                    outValid,
  output      reader_pkg::outKind_type outKind,
  output      logic [3:0]              outErrNum,
  output      logic [reader_pkg::TAG_W-1:0] outData,
  output      reader_pkg::mode_type    mode,
  output      logic [2:0]              lineBaud,
  output      logic                    lineStopTwo,
  output      logic                    echoEnable,
  output      logic                    checkTagReq,
  output      logic                    dlOpValid,
  output      logic [7:0]              dlOp,
  output      logic                    restartReq
);
  import reader_pkg::*;

  function automatic logic isCmd(input logic l, input logic [15:0] c,
                                 input logic [15:0] r);
    return !l && c == r;
  endfunction : isCmd

  mode_type         mode_q;
  logic             ansPend_q;
  outKind_type      ansKind_q;
  logic [TAG_W-1:0] ansData_q;
  logic             ansBaud_q;
  logic             outValid_q;
  outKind_type      outKind_q;
  logic [3:0]       outErrNum_q;
  logic [TAG_W-1:0] outData_q;
  logic             outBaud_q;
  logic [2:0]       baudSel_q;
  logic [2:0]       baudNew_q;
  logic             stopTwo_q;
  logic [2:0]       lineBaud_q;
  logic             lineStopTwo_q;
  logic             echoEnable_q;
  logic             tagReady_q;
  logic             checkTagReq_q;
  logic             dlOpValid_q;
  logic [7:0]       dlOp_q;
  logic             restartReq_q;
  logic [LVL_W-1:0] lvlPrev_q;
  logic             pendWarn_q;
  logic             pendFull_q;
  logic             pendUnfull_q;
  logic             pendHalf_q;
  logic             seenClk_q;

  logic             fifoInReady;
  logic             fifoOutValid;
  logic [TAG_W-1:0] fifoOutData;
  logic [LVL_W-1:0] level;
  logic             push;
  logic             pop;
  logic             slotFree;
  logic             anyPend;
  logic             drainPop;
  logic             sendBaud;

  logic             accept;
  outKind_type      ansKindD;
  logic             goCmd;
  logic             goData;
  logic             goDl;
  logic             exitDl;
  logic             setBaud;
  logic             setStop;
  logic             pollPop;
  logic             chkTag;
  logic             dlGo;
  logic [3:0]       digit;

  logic             setWarn;
  logic             setFull;
  logic             setUnfull;
  logic             setHalf;
  logic             clrWarn;
  logic             clrFull;
  logic             clrUnfull;
  logic             clrHalf;

  tag_fifo #(
    .WIDTH (TAG_W),
    .DEPTH (FIFO_DEPTH),
    .LW    (LVL_W)
  ) u_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (push),
    .inReady  (fifoInReady),
    .inData   (tagId),
    .outValid (fifoOutValid),
    .outReady (pop),
    .outData  (fifoOutData),
    .level    (level)
  );

  // a full buffer takes the tag off the source and drops it
  assign push     = tagValid && tagReady_q && fifoInReady;
  assign slotFree = !outValid_q || outReady;
  assign anyPend  = pendWarn_q || pendFull_q || pendUnfull_q || pendHalf_q;
  assign drainPop = slotFree && !ansPend_q && !anyPend
                    && mode_q == MODE_DATA && fifoOutValid;
  assign pop      = drainPop || pollPop;
  assign sendBaud = outValid_q && outReady && outBaud_q;
  assign digit    = cmdCode[3:0];

  // command decode; a busy answer slot drops the command, host resends
  always_comb begin
    accept   = 1'h0;
    ansKindD = OUT_ERROR;
    goCmd    = 1'h0;
    goData   = 1'h0;
    goDl     = 1'h0;
    exitDl   = 1'h0;
    setBaud  = 1'h0;
    setStop  = 1'h0;
    pollPop  = 1'h0;
    chkTag   = 1'h0;
    dlGo     = 1'h0;
    if (cmdValid && !ansPend_q) begin
      unique case (mode_q)
        MODE_DATA: begin
          if (isCmd(cmdLong, cmdCode, CMD_TO_CMD)) begin
            accept   = 1'h1;
            ansKindD = OUT_DONE;
            goCmd    = 1'h1;
          end else if (isCmd(cmdLong, cmdCode, CMD_TO_DL)) begin
            accept = 1'h1;
          end else if (cmdLong && cmdCode == CMD_CHECK) begin
            accept   = 1'h1;
            ansKindD = OUT_DONE;
            chkTag   = 1'h1;
          end
        end
        MODE_CMD: begin
          accept = 1'h1;
          if (isCmd(cmdLong, cmdCode, CMD_TO_DATA)) begin
            ansKindD = OUT_DONE;
            goData   = 1'h1;
          end else if (isCmd(cmdLong, cmdCode, CMD_TO_CMD)) begin
            ansKindD = OUT_DONE;
          end else if (isCmd(cmdLong, cmdCode, CMD_TO_DL)) begin
            ansKindD = OUT_DONE;
            goDl     = 1'h1;
          end else if (isCmd(cmdLong, cmdCode, CMD_POLL)) begin
            if (ecpEnable && bufCtrlEnable) begin
              ansKindD = fifoOutValid ? OUT_TAG : OUT_DONE;
              pollPop  = fifoOutValid;
            end
          end else if (cmdLong && cmdCode[15:4] == CMD_BAUD_PFX) begin
            if (digit <= {1'h0, BAUD_MAX} && digit[2:0] >= ecpMinBaud) begin
              ansKindD = OUT_DONE;
              setBaud  = 1'h1;
            end
          end else if (cmdLong && cmdCode[15:4] == CMD_STOP_PFX) begin
            if (digit <= STOP_MAX) begin
              ansKindD = OUT_DONE;
              setStop  = 1'h1;
            end
          end
          // anything else keeps the default error answer
        end
        MODE_DL: begin
          if (isCmd(cmdLong, cmdCode, CMD_DL_LOAD)
              || isCmd(cmdLong, cmdCode, CMD_DL_SUM)
              || isCmd(cmdLong, cmdCode, CMD_DL_ERASE)
              || isCmd(cmdLong, cmdCode, CMD_DL_TEST)
              || isCmd(cmdLong, cmdCode, CMD_DL_EXIT)) begin
            accept   = 1'h1;
            ansKindD = OUT_DONE;
            dlGo     = 1'h1;
            exitDl   = isCmd(cmdLong, cmdCode, CMD_DL_EXIT);
          end else begin
            accept = 1'h1;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= MODE_DATA;
    end else if (goCmd) begin
      mode_q <= MODE_CMD;
    end else if (goData || exitDl) begin
      mode_q <= MODE_DATA;
    end else if (goDl) begin
      mode_q <= MODE_DL;
    end
  end

  // answer slot, one per accepted command
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ansPend_q <= 1'h0;
      ansKind_q <= OUT_DONE;
      ansData_q <= '0;
      ansBaud_q <= 1'h0;
    end else if (accept) begin
      ansPend_q <= 1'h1;
      ansKind_q <= ansKindD;
      ansData_q <= fifoOutData;
      ansBaud_q <= setBaud;
    end else if (slotFree) begin
      ansPend_q <= 1'h0;
    end
  end

  // output channel: answer, then error notices, then drained tags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outValid_q  <= 1'h0;
      outKind_q   <= OUT_DONE;
      outErrNum_q <= '0;
      outData_q   <= '0;
      outBaud_q   <= 1'h0;
    end else if (slotFree) begin
      outValid_q <= ansPend_q || anyPend || drainPop;
      outBaud_q  <= ansPend_q && ansBaud_q;
      if (ansPend_q) begin
        outKind_q <= ansKind_q;
        outData_q <= ansData_q;
      end else if (anyPend) begin
        outKind_q <= OUT_ERRNUM;
        outErrNum_q <= pendWarn_q   ? ERR_WARN :
                       pendFull_q   ? ERR_FULL :
                       pendUnfull_q ? ERR_UNFULL : ERR_HALF;
      end else begin
        outKind_q <= OUT_TAG;
        outData_q <= fifoOutData;
      end
    end
  end

  // level edges; a new event wins over the clear of its notice
  assign setWarn   = mode_q == MODE_CMD && level >= LVL_WARN
                     && lvlPrev_q < LVL_WARN;
  assign setFull   = mode_q == MODE_CMD && level == LVL_FULL
                     && lvlPrev_q != LVL_FULL;
  assign setUnfull = mode_q == MODE_DATA && lvlPrev_q == LVL_FULL
                     && level < LVL_FULL;
  assign setHalf   = mode_q == MODE_DATA && lvlPrev_q > LVL_HALF
                     && level == LVL_HALF;
  assign clrWarn   = slotFree && !ansPend_q && pendWarn_q;
  assign clrFull   = slotFree && !ansPend_q && !pendWarn_q && pendFull_q;
  assign clrUnfull = slotFree && !ansPend_q && !pendWarn_q && !pendFull_q
                     && pendUnfull_q;
  assign clrHalf   = slotFree && !ansPend_q && !pendWarn_q && !pendFull_q
                     && !pendUnfull_q && pendHalf_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvlPrev_q    <= '0;
      pendWarn_q   <= 1'h0;
      pendFull_q   <= 1'h0;
      pendUnfull_q <= 1'h0;
      pendHalf_q   <= 1'h0;
    end else begin
      lvlPrev_q    <= level;
      pendWarn_q   <= setWarn || (pendWarn_q && !clrWarn);
      pendFull_q   <= setFull || (pendFull_q && !clrFull);
      pendUnfull_q <= setUnfull || (pendUnfull_q && !clrUnfull);
      pendHalf_q   <= setHalf || (pendHalf_q && !clrHalf);
    end
  end

  // line settings; a new rate waits for its done to leave
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      baudSel_q <= BAUD_DEFAULT;
      baudNew_q <= BAUD_DEFAULT;
      stopTwo_q <= STOP_DEFAULT;
    end else if (exitDl) begin
      baudSel_q <= BAUD_DEFAULT;
      baudNew_q <= BAUD_DEFAULT;
      stopTwo_q <= STOP_DEFAULT;
    end else begin
      if (setBaud) begin
        baudNew_q <= digit[2:0];
      end
      if (sendBaud) begin
        baudSel_q <= baudNew_q;
      end
      if (setStop) begin
        stopTwo_q <= digit[0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lineBaud_q    <= BAUD_DEFAULT;
      lineStopTwo_q <= STOP_DEFAULT;
      echoEnable_q  <= 1'h1;
      tagReady_q    <= 1'h1;
    end else begin
      lineBaud_q    <= mode_q == MODE_DL ? DL_BAUD : baudSel_q;
      lineStopTwo_q <= mode_q == MODE_DL ? DL_STOP_TWO : stopTwo_q;
      echoEnable_q  <= mode_q != MODE_DL;
      tagReady_q    <= mode_q != MODE_DL && !goDl;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      checkTagReq_q <= 1'h0;
      dlOpValid_q   <= 1'h0;
      dlOp_q        <= '0;
      restartReq_q  <= 1'h0;
      seenClk_q     <= 1'h0;
    end else begin
      checkTagReq_q <= chkTag;
      dlOpValid_q   <= dlGo;
      restartReq_q  <= exitDl;
      seenClk_q     <= 1'h1;
      if (dlGo) begin
        dlOp_q <= cmdCode[7:0];
      end
    end
  end

  assign cmdBusy     = ansPend_q;
  assign tagReady    = tagReady_q;
  assign outValid    = outValid_q;
  assign outKind     = outKind_q;
  assign outErrNum   = outErrNum_q;
  assign outData     = outData_q;
  assign mode        = mode_q;
  assign lineBaud    = lineBaud_q;
  assign lineStopTwo = lineStopTwo_q;
  assign echoEnable  = echoEnable_q;
  assign checkTagReq = checkTagReq_q;
  assign dlOpValid   = dlOpValid_q;
  assign dlOp        = dlOp_q;
  assign restartReq  = restartReq_q;

  property p_startData;
    @(posedge clk) disable iff (!rst_n) !seenClk_q |-> mode_q == MODE_DATA;
  endproperty
  a_startData: assert property (p_startData)
    else $error("not in data mode after reset");

  property p_dataIgnore;
    @(posedge clk) disable iff (!rst_n)
      mode_q == MODE_DATA && cmdValid && !ansPend_q && !cmdLong
      && cmdCode != CMD_TO_CMD && cmdCode != CMD_TO_DL |=> !ansPend_q;
  endproperty
  a_dataIgnore: assert property (p_dataIgnore)
    else $error("data mode answered an ignored command");

  property p_noDrainOutsideData;
    @(posedge clk) disable iff (!rst_n)
      mode_q == MODE_CMD && !pollPop |=> level >= $past(level);
  endproperty
  a_noDrainOutsideData: assert property (p_noDrainOutsideData)
    else $error("tag forwarded outside data mode");

  property p_toData;
    @(posedge clk) disable iff (!rst_n)
      mode_q == MODE_CMD && cmdValid && !ansPend_q
      && isCmd(cmdLong, cmdCode, CMD_TO_DATA)
      |=> mode_q == MODE_DATA && ansPend_q && ansKind_q == OUT_DONE;
  endproperty
  a_toData: assert property (p_toData)
    else $error("command 00 did not return to data mode with done");

  property p_oneAnswer;
    @(posedge clk) disable iff (!rst_n)
      mode_q == MODE_CMD && cmdValid && !ansPend_q |=> ansPend_q ##[1:300] outValid_q;
  endproperty
  a_oneAnswer: assert property (p_oneAnswer)
    else $error("command in command mode got no answer");

  property p_baudAfterDone;
    @(posedge clk) disable iff (!rst_n)
      sendBaud && !exitDl |=> baudSel_q == $past(baudNew_q);
  endproperty
  a_baudAfterDone: assert property (p_baudAfterDone)
    else $error("baud rate not switched after done");

  property p_warn;
    @(posedge clk) disable iff (!rst_n)
      setWarn |-> ##[1:300] (outValid_q && outKind_q == OUT_ERRNUM
                             && outErrNum_q == ERR_WARN);
  endproperty
  a_warn: assert property (p_warn)
    else $error("three quarter notice lost");

  property p_fullDrops;
    @(posedge clk) disable iff (!rst_n)
      level == LVL_FULL && !pop |=> level == LVL_FULL;
  endproperty
  a_fullDrops: assert property (p_fullDrops)
    else $error("tag stored into a full buffer");

  property p_dlFixed;
    @(posedge clk) disable iff (!rst_n)
      mode_q == MODE_DL ##1 mode_q == MODE_DL
      |-> lineBaud_q == DL_BAUD && !echoEnable_q;
  endproperty
  a_dlFixed: assert property (p_dlFixed)
    else $error("download line settings not fixed");

  property p_dlRefused;
    @(posedge clk) disable iff (!rst_n)
      mode_q == MODE_DATA && cmdValid && !ansPend_q
      && isCmd(cmdLong, cmdCode, CMD_TO_DL)
      |=> mode_q == MODE_DATA && ansKind_q == OUT_ERROR;
  endproperty
  a_dlRefused: assert property (p_dlRefused)
    else $error("download entered from data mode");

endmodule : reader_mode_command_handler

/* File: design/reader_pkg.sv */
package reader_pkg;

  localparam int TAG_W      = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int LVL_W      = 4;

  // buffer levels: three quarters, full, one half
  localparam logic [LVL_W-1:0] LVL_WARN = 4'h6;
  localparam logic [LVL_W-1:0] LVL_FULL = 4'h8;
  localparam logic [LVL_W-1:0] LVL_HALF = 4'h4;

  // commands, written as BCD digits
  localparam logic [15:0] CMD_TO_DATA  = 16'h0000;
  localparam logic [15:0] CMD_TO_CMD   = 16'h0001;
  localparam logic [15:0] CMD_TO_DL    = 16'h0005;
  localparam logic [15:0] CMD_POLL     = 16'h0006;
  localparam logic [15:0] CMD_CHECK    = 16'h8110;
  localparam logic [11:0] CMD_BAUD_PFX = 12'h100;
  localparam logic [11:0] CMD_STOP_PFX = 12'h101;
  localparam logic [15:0] CMD_DL_LOAD  = 16'h0090;
  localparam logic [15:0] CMD_DL_SUM   = 16'h0091;
  localparam logic [15:0] CMD_DL_ERASE = 16'h0096;
  localparam logic [15:0] CMD_DL_TEST  = 16'h0097;
  localparam logic [15:0] CMD_DL_EXIT  = 16'h0099;

  // rate index: 0=110 1=300 2=1200 3=2400 4=4800 5=9600 6=19200
  localparam logic [2:0] BAUD_DEFAULT = 3'h5;
  localparam logic [2:0] BAUD_MAX     = 3'h6;
  localparam logic [2:0] DL_BAUD      = 3'h5;
  localparam logic [3:0] STOP_MAX     = 4'h1;
  localparam logic       STOP_DEFAULT = 1'h0;
  localparam logic       DL_STOP_TWO  = 1'h0;

  localparam logic [3:0] ERR_FULL   = 4'h2;
  localparam logic [3:0] ERR_UNFULL = 4'h3;
  localparam logic [3:0] ERR_WARN   = 4'h4;
  localparam logic [3:0] ERR_HALF   = 4'h5;

  typedef enum logic [1:0] {
    MODE_DATA = 2'h0,
    MODE_CMD  = 2'h1,
    MODE_DL   = 2'h3
  } mode_type;

  typedef enum logic [1:0] {
    OUT_DONE   = 2'h0,
    OUT_ERROR  = 2'h1,
    OUT_ERRNUM = 2'h2,
    OUT_TAG    = 2'h3
  } outKind_type;

endpackage : reader_pkg

/* File: design/tag_fifo.sv */
`timescale 1ns/1ns
module tag_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int LW    = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             inValid,
  output      logic             inReady,
  input  wire logic [WIDTH-1:0] inData,
  output      logic             outValid,
  input  wire logic             outReady,
  output      logic [WIDTH-1:0] outData,
  output      logic [LW-1:0]    level
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wrPtr_q;
  logic [PW-1:0]    rdPtr_q;
  logic [LW-1:0]    count_q;
  logic             push;
  logic             pop;

  assign inReady  = count_q != LW'(DEPTH);
  assign outValid = count_q != '0;
  assign outData  = mem_q[rdPtr_q];
  assign level    = count_q;
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + PW'(1);
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + PW'(1);
      end
      if (push && !pop) begin
        count_q <= count_q + LW'(1);
      end else if (pop && !push) begin
        count_q <= count_q - LW'(1);
      end
    end
  end

endmodule : tag_fifo

/* File: sim/host_model.sv */
`timescale 1ns/1ns
module host_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic slow,
  output      logic outReady
);
  // host transmitter takes each word at once, or stalls at random
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outReady <= 1'b0;
    end else begin
      outReady <= !slow || ($urandom % 3 == 0);
    end
  end
endmodule : host_model

/* File: sim/tb_reader_mode_command_handler.sv */
`timescale 1ns/1ns
module tb_reader_mode_command_handler;
  import reader_pkg::*;
  logic        clk = 0, rst_n = 0, cmdValid = 0, cmdLong = 0, slow = 0;
  logic        tagValid = 0, ecpEnable = 0, bufCtrlEnable = 0;
  logic [15:0] cmdCode = 16'h0000, tagId = 16'h0000, outData;
  logic [2:0]  ecpMinBaud = 3'h0, lineBaud;
  logic        cmdBusy, tagReady, outReady, outValid, lineStopTwo;
  logic        echoEnable, checkTagReq, dlOpValid, restartReq;
  logic        sawCheck = 0, sawRestart = 0;
  logic [3:0]  outErrNum;
  logic [7:0]  dlOp, lastOp = 8'h00;
  outKind_type outKind;
  mode_type    mode;
  int          badCount = 0, numChecks = 0;
  logic [15:0] ansQ[$], ntcQ[$], tagQ[$];
  logic [15:0] ops[4] = '{CMD_DL_LOAD, CMD_DL_SUM, CMD_DL_ERASE, CMD_DL_TEST};

  reader_mode_command_handler dut (.*);
  host_model host (.*);

  always #25 clk = ~clk;

  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tallyAndFinish

  task automatic chkVal(input string n, input logic [15:0] e, input logic [15:0] g);
    numChecks++;
    if (g !== e) begin
      badCount++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chkVal

  task automatic chkWord(input string n, ref logic [15:0] q[$], input logic [15:0] g);
    chkVal(n, (q.size() > 0) ? q.pop_front() : 16'hFFFF, g);
  endtask : chkWord

  // every word the host takes is matched against its own queue
  always @(posedge clk) begin
    if (checkTagReq) sawCheck <= 1'b1;
    if (restartReq) sawRestart <= 1'b1;
    if (dlOpValid) lastOp <= dlOp;
    if (rst_n && outValid && outReady) begin
      case (outKind)
        OUT_TAG: chkWord("tag", tagQ, outData);
        OUT_ERRNUM: chkWord("notice", ntcQ, {12'h000, outErrNum});
        default: chkWord("answer", ansQ, {14'h0000, outKind});
      endcase
    end
  end

  task automatic settle(input bit all);
    repeat (400) if (ansQ.size() + ntcQ.size() + (all ? tagQ.size() : 0) > 0) @(posedge clk);
    chkVal("pending", 16'h0000, 16'(ansQ.size() + ntcQ.size() + (all ? tagQ.size() : 0)));
    repeat (4) @(posedge clk);
  endtask : settle

  task automatic send(input logic [15:0] c, input logic lg, input int ans);
    if (ans >= 0) ansQ.push_back(ans[15:0]);
    cmdValid <= 1'b1;
    cmdCode <= c;
    cmdLong <= lg;
    @(posedge clk);
    // met by cmdBusy the command is dropped; the host times out and resends
    for (int t = 0; t < 20 && cmdBusy === 1'b1; t++) begin
      cmdValid <= 1'b0;
      repeat (4) @(posedge clk);
      cmdValid <= 1'b1;
      @(posedge clk);
    end
  endtask : send

  task automatic cmd(input logic [15:0] c, input logic lg, input int ans);
    send(c, lg, ans);
    cmdValid <= 1'b0;
    settle(0);
  endtask : cmd

  task automatic tag(input bit kept);
    logic [15:0] v;
    v = 16'($urandom);
    if (kept) tagQ.push_back(v);
    tagValid <= 1'b1;
    tagId <= v;
    @(posedge clk);
    repeat (50) if (tagReady !== 1'b1) @(posedge clk);
    tagValid <= 1'b0;
    @(posedge clk);
  endtask : tag

  initial begin
    void'($urandom(64419));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chkVal("mode", MODE_DATA, mode);
    chkVal("echo", 16'h0001, echoEnable);
    tag(1);
    settle(1);
    cmd(CMD_POLL, 0, -1);
    cmd(CMD_TO_DL, 0, OUT_ERROR);
    cmd(CMD_CHECK, 1, OUT_DONE);
    chkVal("check", 16'h0001, sawCheck);
    cmd(CMD_TO_CMD, 0, OUT_DONE);
    ecpEnable <= 1'b1;
    bufCtrlEnable <= 1'b1;
    slow <= 1'b1;
    tag(1);
    cmd(CMD_POLL, 0, -1);
    settle(1);
    cmd(CMD_POLL, 0, OUT_DONE);
    for (int i = 1; i <= 9; i++) begin
      tag(i < 9);
      if (i == 6) ntcQ.push_back(ERR_WARN);
      if (i == 8) ntcQ.push_back(ERR_FULL);
    end
    ecpEnable <= 1'b0;
    cmd(CMD_POLL, 0, OUT_ERROR);
    ntcQ.push_back(ERR_UNFULL);
    ntcQ.push_back(ERR_HALF);
    cmd(CMD_TO_DATA, 0, OUT_DONE);
    settle(1);
    slow <= 1'b0;
    cmd(CMD_TO_CMD, 0, OUT_DONE);
    for (int n = 0; n <= 6; n++) begin
      cmd({CMD_BAUD_PFX, 4'(n)}, 1, OUT_DONE);
      chkVal("baud", 16'(n), lineBaud);
    end
    cmd(16'h1007, 1, OUT_ERROR);
    ecpMinBaud <= 3'h4;
    cmd(16'h1003, 1, OUT_ERROR);
    chkVal("baud", 16'h0006, lineBaud);
    cmd(16'h1011, 1, OUT_DONE);
    chkVal("stop", 16'h0001, lineStopTwo);
    send(16'h1012, 1, OUT_ERROR);
    send(16'h0042, 0, OUT_ERROR);
    cmdValid <= 1'b0;
    settle(0);
    cmd(CMD_TO_DL, 0, OUT_DONE);
    chkVal("mode", MODE_DL, mode);
    chkVal("baud", DL_BAUD, lineBaud);
    chkVal("stop", DL_STOP_TWO, lineStopTwo);
    chkVal("echo", 16'h0000, echoEnable);
    chkVal("tagReady", 16'h0000, tagReady);
    foreach (ops[i]) begin
      cmd(ops[i], 0, OUT_DONE);
      chkVal("dlOp", ops[i], lastOp);
    end
    cmd(CMD_TO_CMD, 0, OUT_ERROR);
    cmd(CMD_DL_EXIT, 0, OUT_DONE);
    chkVal("restart", 16'h0001, sawRestart);
    chkVal("mode", MODE_DATA, mode);
    chkVal("baud", BAUD_DEFAULT, lineBaud);
    chkVal("stop", STOP_DEFAULT, lineStopTwo);
    tallyAndFinish();
  end

  initial begin
    repeat (30000) @(posedge clk);
    badCount++;
    tallyAndFinish();
  end
endmodule : tb_reader_mode_command_handler
